// ### rtl/oco_cache.sv
`timescale 1ns/1ps
`default_nettype none
module oco_cache #(
  parameter bit OPERAND = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpu_req,
  input  wire logic        cpu_write,
  input  wire logic        cpu_line_preload_op,
  input  wire logic        cpu_cacheable,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [31:0] cpu_wdata,
  output logic             cpu_idle,
  output logic             cpu_done,
  output logic      [31:0] cpu_rdata,
  output logic             mem_req,
  output logic             mem_write,
  output logic             mem_burst,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);
  import oco_pkg::*;

  oco_state_t state_ff;
  logic        req_we_ff, req_pf_ff, req_ca_ff;
  logic [31:0] req_addr_ff, req_wd_ff, c1_ff, c2_ff;
  logic        idle_ff, done_ff, pready_ff, pslverr_ff;
  logic [31:0] rdata_ff, prdata_ff;
  logic [OCO_TAG_W-1:0] tag_mem [OCO_WAYS][OCO_SETS];
  logic [31:0]          data_mem [OCO_WAYS][OCO_SETS*OCO_BEATS];
  logic [OCO_SETS-1:0]  valid_ff [OCO_WAYS];
  logic [OCO_SETS-1:0]  dirty_ff [OCO_WAYS];
  logic [OCO_LRU_W-1:0] lru_ff [OCO_SETS];
  logic [31:0] wb_data_ff [OCO_BEATS];
  logic [27:0] wb_line_ff;
  logic [1:0]  wb_start_ff, beat_ff, vict_ff;
  logic        wb_full_ff, dr_act_ff;
  logic        mreq_ff, mwe_ff, mburst_ff;
  logic [31:0] maddr_ff, mwd_ff;

  logic [6:0]           idx;
  logic [OCO_TAG_W-1:0] tag;
  logic [1:0]           off, hit_way, lru_way, vict, boff;
  wire  [OCO_WAYS-1:0]  hit_w;
  logic [OCO_WAYS-1:0]  allow;
  logic on, wt, le, is_pf, cache_on, hit, need_evict;
  logic to_sgl, to_fill, stall, go_bus, look_fin, dr_start, last, in_look, hit_upd;

  // Request fields
  assign idx  = req_addr_ff[OCO_IDX_HI:OCO_IDX_LO];
  assign tag  = req_addr_ff[OCO_ADDR_HI:OCO_TAG_LO];
  assign off  = req_addr_ff[OCO_OFF_HI:OCO_OFF_LO];
  assign boff = maddr_ff[OCO_OFF_HI:OCO_OFF_LO];
  assign on   = c1_ff[OCO_C1_ON];
  assign wt   = c1_ff[OCO_C1_WT];
  assign le   = c2_ff[OCO_C2_LE];
  assign in_look = (state_ff == OCO_LOOK);
  // The instruction variant never prefetches and sends writes around the cache
  assign is_pf    = req_pf_ff & OPERAND;
  assign cache_on = on & req_ca_ff & (OPERAND | ~req_we_ff);

  // Tag compare in all ways at once
  for (genvar w = 0; w < OCO_WAYS; w++) begin : g_cmp
    assign hit_w[w] = valid_ff[w][idx] & (tag_mem[w][idx] == tag);
  end
  assign hit = |hit_w;

  always_comb begin
    hit_way = 2'h0;
    for (int w = 0; w < OCO_WAYS; w++) begin
      if (hit_w[w]) hit_way = w[1:0];
    end
  end

  // Locked ways leave the candidate set
  always_comb begin
    allow = '1;
    if (le) begin
      allow[OCO_WAY2] = ~c2_ff[OCO_C2_W2PIN];
      allow[OCO_WAY3] = ~c2_ff[OCO_C2_W3PIN];
    end
  end

  oco_victim u_victim (
    .lru   (lru_ff[idx]),
    .allow (allow),
    .way   (lru_way)
  );

  // Way 3 target checked first; both targets set is a software fault
  always_comb begin
    vict = lru_way;
    if (le && is_pf && c2_ff[OCO_C2_W3FILL]) vict = OCO_WAY3;
    else if (le && is_pf && c2_ff[OCO_C2_W2FILL]) vict = OCO_WAY2;
  end

  assign need_evict = OPERAND & ~wt & valid_ff[vict][idx] & dirty_ff[vict][idx];

  // What the looked-up request needs next
  always_comb begin
    to_sgl  = 1'b0;
    to_fill = 1'b0;
    if (!cache_on) to_sgl = ~is_pf;
    else if (hit) to_sgl = req_we_ff & wt;
    else if (req_we_ff && wt) to_sgl = 1'b1;
    else to_fill = 1'b1;
  end

  // A second dirty victim waits for the buffer; the bus waits for a drain
  assign stall    = to_fill & need_evict & wb_full_ff;
  assign go_bus   = in_look & (to_sgl | to_fill) & ~dr_act_ff & ~stall;
  assign look_fin = in_look & ~to_sgl & ~to_fill;
  assign hit_upd  = in_look & cache_on & hit & (look_fin | go_bus);
  assign dr_start = wb_full_ff & ~dr_act_ff
                  & ((state_ff == OCO_IDLE) | (in_look & ~go_bus));
  assign last     = mreq_ff & mem_ack & (~mburst_ff | (beat_ff == OCO_LAST_BEAT));

  // Control sequence
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= OCO_IDLE;
      idle_ff  <= 1'b1;
    end else begin
      case (state_ff)
        OCO_IDLE: begin
          if (cpu_req) begin
            state_ff <= OCO_LOOK;
            idle_ff  <= 1'b0;
          end
        end
        OCO_LOOK: begin
          if (go_bus) begin
            state_ff <= to_fill ? OCO_FILL : OCO_SGL;
          end else if (look_fin) begin
            state_ff <= OCO_IDLE;
            idle_ff  <= 1'b1;
          end
        end
        OCO_FILL, OCO_SGL: begin
          if (last) begin
            state_ff <= OCO_IDLE;
            idle_ff  <= 1'b1;
          end
        end
        default: begin
          state_ff <= OCO_IDLE;
          idle_ff  <= 1'b1;
        end
      endcase
    end
  end

  // Request capture, only while idle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_we_ff   <= 1'b0;
      req_pf_ff   <= 1'b0;
      req_ca_ff   <= 1'b0;
      req_addr_ff <= OCO_RST_VAL;
      req_wd_ff   <= OCO_RST_VAL;
      vict_ff     <= 2'h0;
    end else begin
      if (state_ff == OCO_IDLE && cpu_req) begin
        req_we_ff   <= cpu_write;
        req_pf_ff   <= cpu_line_preload_op;
        req_ca_ff   <= cpu_cacheable;
        req_addr_ff <= cpu_addr;
        req_wd_ff   <= cpu_wdata;
      end
      if (go_bus) vict_ff <= vict;
    end
  end

  // Answers to the CPU; the missed word is passed on as it arrives
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      done_ff  <= 1'b0;
      rdata_ff <= OCO_RST_VAL;
    end else begin
      done_ff <= 1'b0;
      if (look_fin) begin
        done_ff <= 1'b1;
        if (cache_on && !req_we_ff && !is_pf) begin
          rdata_ff <= data_mem[hit_way][{idx, off}];
        end
      end
      if (state_ff == OCO_FILL && mreq_ff && mem_ack) begin
        if (!req_we_ff && !is_pf && boff == off) begin
          rdata_ff <= mem_rdata;
          done_ff  <= 1'b1;
        end
        if (last && (req_we_ff || is_pf)) done_ff <= 1'b1;
      end
      if (state_ff == OCO_SGL && last) begin
        done_ff <= 1'b1;
        if (!req_we_ff) rdata_ff <= mem_rdata;
      end
    end
  end

  // Tags, line data and buffer words carry no reset
  always_ff @(posedge sys_clk) begin
    if (hit_upd && req_we_ff) begin
      data_mem[hit_way][{idx, off}] <= req_wd_ff;
    end
    if (state_ff == OCO_FILL && mreq_ff && mem_ack) begin
      data_mem[vict_ff][{idx, boff}] <= (req_we_ff && boff == off)
                                       ? req_wd_ff : mem_rdata;
    end
    if (state_ff == OCO_FILL && last) begin
      tag_mem[vict_ff][idx] <= {{(OCO_TAG_W-OCO_TAG_LIVE){1'b0}},
                                tag[OCO_TAG_LIVE-1:0]};
    end
    // Victim copied out before the fill overwrites it
    if (go_bus && to_fill && need_evict) begin
      for (int k = 0; k < OCO_BEATS; k++) begin
        wb_data_ff[k] <= data_mem[vict][{idx, k[1:0]}];
      end
      wb_line_ff  <= {tag_mem[vict][idx], idx};
      wb_start_ff <= off;
    end
  end

  // Entry flags and LRU
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int w = 0; w < OCO_WAYS; w++) begin
        valid_ff[w] <= '0;
        dirty_ff[w] <= '0;
      end
      for (int s = 0; s < OCO_SETS; s++) begin
        lru_ff[s] <= OCO_LRU_RST;
      end
    end else begin
      if (hit_upd) begin
        lru_ff[idx] <= oco_lru_touch(lru_ff[idx], hit_way);
        if (req_we_ff && !wt) dirty_ff[hit_way][idx] <= 1'b1;
      end
      if (state_ff == OCO_FILL && last) begin
        valid_ff[vict_ff][idx] <= 1'b1;
        dirty_ff[vict_ff][idx] <= req_we_ff & OPERAND;
        lru_ff[idx] <= oco_lru_touch(lru_ff[idx], vict_ff);
      end
    end
  end

  // Write-back buffer state; it drains only once the main fill is over
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_full_ff <= 1'b0;
      dr_act_ff  <= 1'b0;
    end else begin
      if (go_bus && to_fill && need_evict) wb_full_ff <= 1'b1;
      if (dr_start) dr_act_ff <= 1'b1;
      if (dr_act_ff && last) begin
        dr_act_ff  <= 1'b0;
        wb_full_ff <= 1'b0;
      end
    end
  end

  // External bus; one owner at a time, bursts step the word in wrap order
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mreq_ff   <= 1'b0;
      mwe_ff    <= 1'b0;
      mburst_ff <= 1'b0;
      maddr_ff  <= OCO_RST_VAL;
      mwd_ff    <= OCO_RST_VAL;
      beat_ff   <= 2'h0;
    end else if (go_bus) begin
      mreq_ff   <= 1'b1;
      mburst_ff <= to_fill;
      mwe_ff    <= to_sgl & req_we_ff;
      maddr_ff  <= to_fill ? {req_addr_ff[OCO_ADDR_HI:OCO_IDX_LO], off, 2'h0}
                           : req_addr_ff;
      mwd_ff    <= req_wd_ff;
      beat_ff   <= 2'h0;
    end else if (dr_start) begin
      mreq_ff   <= 1'b1;
      mburst_ff <= 1'b1;
      mwe_ff    <= 1'b1;
      maddr_ff  <= {wb_line_ff, wb_start_ff, 2'h0};
      mwd_ff    <= wb_data_ff[wb_start_ff];
      beat_ff   <= 2'h0;
    end else if (mreq_ff && mem_ack) begin
      if (last) begin
        mreq_ff <= 1'b0;
      end else begin
        beat_ff <= beat_ff + 2'h1;
        maddr_ff[OCO_OFF_HI:OCO_OFF_LO] <= boff + 2'h1;
        mwd_ff  <= wb_data_ff[boff + 2'h1];
      end
    end
  end

  // APB slave, one wait state; writes land with pready
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= OCO_RST_VAL;
      c1_ff      <= OCO_RST_VAL;
      c2_ff      <= OCO_RST_VAL;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      if (psel && penable && !pready_ff) begin
        pslverr_ff <= 1'b0;
        prdata_ff  <= OCO_RST_VAL;
        case (paddr)
          OCO_REG_CTRL1: prdata_ff <= c1_ff;
          OCO_REG_CTRL2: prdata_ff <= c2_ff;
          OCO_REG_STAT:  prdata_ff <= {29'h0, dr_act_ff, wb_full_ff, ~idle_ff};
          default:       pslverr_ff <= 1'b1;
        endcase
      end
      if (psel && penable && pready_ff && pwrite) begin
        if (paddr == OCO_REG_CTRL1) c1_ff <= pwdata & OCO_C1_MASK;
        if (paddr == OCO_REG_CTRL2) c2_ff <= pwdata & OCO_C2_MASK;
      end
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign cpu_idle  = idle_ff;
  assign cpu_done  = done_ff;
  assign cpu_rdata = rdata_ff;
  assign mem_req   = mreq_ff;
  assign mem_write = mwe_ff;
  assign mem_burst = mburst_ff;
  assign mem_addr  = maddr_ff;
  assign mem_wdata = mwd_ff;

  // Checks
  rd_hit_data_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    look_fin && cache_on && !req_we_ff && !is_pf |=> done_ff
      && rdata_ff == $past(data_mem[hit_way][{idx, off}]))
    else $error("read hit data wrong");
  pf_hit_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    look_fin && is_pf |=> $stable(rdata_ff) && !(mreq_ff && !dr_act_ff))
    else $error("prefetch hit touched data");
  wb_hit_local_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    in_look && cache_on && hit && req_we_ff && !wt |=> state_ff == OCO_IDLE && done_ff)
    else $error("write-back hit went external");
  wt_miss_ext_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    go_bus && cache_on && !hit && req_we_ff && wt
      |=> state_ff == OCO_SGL && mwe_ff && !mburst_ff)
    else $error("write-through miss allocated");
  fill_burst_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    go_bus && to_fill |=> mreq_ff && mburst_ff && !mwe_ff && state_ff == OCO_FILL)
    else $error("refill is not a read burst");
  wrap_step_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mreq_ff && mburst_ff && mem_ack && !last
      |=> maddr_ff[OCO_OFF_HI:OCO_OFF_LO] == $past(boff) + 2'h1)
    else $error("burst order not wrapped");
  drain_late_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(dr_act_ff && state_ff == OCO_FILL))
    else $error("drain overlapped the fill");
  evict_stall_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    in_look && stall |=> in_look)
    else $error("dirty eviction not stalled");
  lock_skip_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    go_bus && to_fill && le && !is_pf && c2_ff[OCO_C2_W2PIN] |-> vict != OCO_WAY2)
    else $error("locked way replaced");
  pf_target_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    go_bus && to_fill && le && is_pf && c2_ff[OCO_C2_W3FILL] |-> vict == OCO_WAY3)
    else $error("prefetch target ignored");
  rd_miss_c: cover property (@(posedge sys_clk) go_bus && to_fill && !req_we_ff && !is_pf);
  drain_c: cover property (@(posedge sys_clk) dr_act_ff && last);
  pf_hit_c: cover property (@(posedge sys_clk) look_fin && is_pf && hit);
  stall_c: cover property (@(posedge sys_clk) in_look && stall);
endmodule
`default_nettype wire

// ### rtl/oco_pkg.sv
// Summary of operation
// - With data_cache_on set, every cacheable access performs a lookup.
// - Set index comes from access address bits 10 to 4.
// - Address bits 31 to 11 compared in all four ways; tag top three bits zero.
// - Hit needs a tag match and a set valid flag; otherwise miss.
// - Read hit returns data and makes the hit way most recent.
// - Read miss fills a whole 16-byte line, forwarding the missed word.
// - After read fill: valid set, modified cleared, replaced way most recent.
// - With write-through clear, a dirty victim goes to write-back buffer; buffer drains after the fill.
// - Fills and write-backs run in wrap-around longword order from the missed offset.
// - Prefetch hit only refreshes LRU; no data fetched or returned.
// - Prefetch miss fills like a read miss but returns no data.
// - Write-back write hit updates line, sets modified, no external write.
// - Write-through write hit updates line and writes externally; modified unchanged.
// - Write-back write miss allocates, fills, merges data, sets modified and valid.
// - Write-through write miss writes only external memory, no allocation.
// - Write-back buffer holds one line plus address; cache usable while draining.
// - Lock mode prefetch miss targets way 2 or 3 per fill-target bits.
// - Lock mode ordinary misses use LRU excluding locked ways 2 and 3.
// - Refill is a 16-byte read burst, drain a 16-byte write burst.
// - Instruction variant drops modified flag, prefetch, writes and buffer.
// - 128 entries per way, six LRU bits per entry reset to zero.
// - Valid and modified clear on reset; tags and data are never initialised.
// - Configuration bits select write-through mode and enable way lock mode.
package oco_pkg;
  localparam int OCO_WAYS      = 4;
  localparam int OCO_SETS      = 128;
  localparam int OCO_BEATS     = 4;
  localparam int OCO_LRU_W     = 6;
  localparam int OCO_ADDR_HI   = 31;
  localparam int OCO_IDX_HI    = 10;
  localparam int OCO_IDX_LO    = 4;
  localparam int OCO_TAG_LO    = 11;
  localparam int OCO_TAG_W     = 21;
  localparam int OCO_TAG_LIVE  = 18;
  localparam int OCO_OFF_HI    = 3;
  localparam int OCO_OFF_LO    = 2;
  localparam logic [1:0] OCO_WAY2      = 2'h2;
  localparam logic [1:0] OCO_WAY3      = 2'h3;
  localparam logic [1:0] OCO_LAST_BEAT = 2'h3;
  localparam logic [5:0] OCO_LRU_RST   = 6'h00;
  // APB map, byte addresses
  localparam logic [11:0] OCO_REG_CTRL1 = 12'h000;
  localparam logic [11:0] OCO_REG_CTRL2 = 12'h004;
  localparam logic [11:0] OCO_REG_STAT  = 12'h008;
  // Field positions
  localparam int OCO_C1_ON     = 0;
  localparam int OCO_C1_WT     = 1;
  localparam int OCO_C2_W2PIN  = 0;
  localparam int OCO_C2_W2FILL = 1;
  localparam int OCO_C2_W3PIN  = 8;
  localparam int OCO_C2_W3FILL = 9;
  localparam int OCO_C2_LE     = 16;
  localparam logic [31:0] OCO_C1_MASK = 32'h0000_0003;
  localparam logic [31:0] OCO_C2_MASK = 32'h0001_0303;
  localparam logic [31:0] OCO_RST_VAL = 32'h0000_0000;

  typedef enum logic [1:0] {
    OCO_IDLE = 2'b00,
    OCO_LOOK = 2'b01,
    OCO_FILL = 2'b10,
    OCO_SGL  = 2'b11
  } oco_state_t;

  // Bit of the pair (lo, hi); a one means the higher way is older
  function automatic int oco_pair(input int hi, input int lo);
    return hi * (hi - 1) / 2 + lo;
  endfunction

  // Makes one way the most recent
  function automatic logic [5:0] oco_lru_touch(input logic [5:0] lru, input logic [1:0] way);
    logic [5:0] r;
    r = lru;
    for (int v = 0; v < OCO_WAYS; v++) begin
      if (v < int'(way)) r[oco_pair(int'(way), v)] = 1'b0;
      else if (v > int'(way)) r[oco_pair(v, int'(way))] = 1'b1;
    end
    return r;
  endfunction
endpackage

// ### rtl/oco_victim.sv
`timescale 1ns/1ps
`default_nettype none
module oco_victim (
  input  wire logic [oco_pkg::OCO_LRU_W-1:0] lru,
  input  wire logic [oco_pkg::OCO_WAYS-1:0]  allow,
  output logic      [1:0]                    way
);
  import oco_pkg::*;
  wire [OCO_WAYS-1:0] oldest;

  // A way is the victim when it is older than every other allowed way
  for (genvar w = 0; w < OCO_WAYS; w++) begin : g_old
    logic old_w;
    always_comb begin
      old_w = allow[w];
      for (int v = 0; v < OCO_WAYS; v++) begin
        if (v < w && allow[v] && !lru[oco_pair(w, v)]) old_w = 1'b0;
        if (v > w && allow[v] && lru[oco_pair(v, w)]) old_w = 1'b0;
      end
    end
    assign oldest[w] = old_w;
  end

  // Legal LRU patterns give one candidate; lowest wins otherwise
  always_comb begin
    way = 2'h0;
    for (int w = OCO_WAYS - 1; w >= 0; w--) begin
      if (oldest[w]) way = w[1:0];
    end
  end
endmodule
`default_nettype wire

// ### tb/oco_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module oco_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  slow,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata,
  output int               rd_beats,
  output int               wr_beats,
  output logic      [7:0]  beat_seq
);
  logic [31:0] store [logic [31:0]];
  logic [1:0]  wait_ff;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    rd_beats = 0;
    wr_beats = 0;
    beat_seq = 8'h0;
    wait_ff = 2'h0;
  end
  // One ack per beat, then a gap so the next beat address has settled
  always @(posedge sys_clk) begin
    if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // Released bus inverts each cycle, so the first one never repeats the last value
      wait_ff <= slow;
    end else if (wait_ff != 2'h0) begin
      wait_ff <= wait_ff - 2'h1;
    end else begin
      mem_ack <= 1'b1;
      mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : ~mem_addr;
      beat_seq <= {beat_seq[5:0], mem_addr[3:2]};
      if (mem_write) begin
        store[mem_addr] = mem_wdata;
        wr_beats <= wr_beats + 1;
      end else begin
        rd_beats <= rd_beats + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/test_operand_cache_ops.sv
`timescale 1ns/1ps
`default_nettype none
module test_operand_cache_ops;
  import oco_pkg::*;
  logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic        cpu_req, cpu_write, cpu_line_preload_op, cpu_cacheable, cpu_idle, cpu_done;
  logic        mem_req, mem_write, mem_burst, mem_ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cpu_addr, cpu_wdata, cpu_rdata, rd;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  logic [1:0]  slow;
  logic [7:0]  beat_seq;
  int          rd_beats, wr_beats, n_errors, n_checks, r0, w0;

  oco_cache dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_line_preload_op(cpu_line_preload_op),
    .cpu_cacheable(cpu_cacheable), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_idle(cpu_idle), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .mem_req(mem_req),
    .mem_write(mem_write), .mem_burst(mem_burst), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  oco_mem_model mem (.sys_clk(sys_clk), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .slow(slow), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .rd_beats(rd_beats), .wr_beats(wr_beats), .beat_seq(beat_seq));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic give_verdict;
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    chk(32'(got), 32'(exp));
  endtask
  // Expected beat offsets of a wrapped burst starting at o
  function automatic logic [7:0] seq_of(input logic [1:0] o);
    return {o, o + 2'h1, o + 2'h2, o + 2'h3};
  endfunction
  // APB transfer; entered just after a rising edge, leaves one edge after release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (int i = 0; i < 50 && pready !== 1'b1; i++) @(posedge sys_clk);
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Request held until taken, then wait for the done pulse
  task automatic cpu(input logic w, p, c, input logic [31:0] a, d);
    cpu_req <= 1'b1;
    cpu_write <= w;
    cpu_line_preload_op <= p;
    cpu_cacheable <= c;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge sys_clk);
    for (int i = 0; i < 50 && cpu_idle !== 1'b1; i++) @(posedge sys_clk);
    cpu_req <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 200 && cpu_done !== 1'b1; i++) @(posedge sys_clk);
    if (cpu_done !== 1'b1) n_errors++;
    rd = cpu_rdata;
    // A read miss answers before its burst ends; later checks need the bus quiet
    for (int i = 0; i < 200 && cpu_idle !== 1'b1; i++) @(posedge sys_clk);
  endtask
  initial begin
    #200us;
    n_errors++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, cpu_req, cpu_write, cpu_line_preload_op, cpu_cacheable} = 7'h0;
    {paddr, pwdata, cpu_addr, cpu_wdata} = '0;
    slow = 2'h0;
    reset_n = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, OCO_REG_CTRL1, 32'h0); chk(rd, OCO_RST_VAL);
    apb(1'b0, 12'h010, 32'h0); chk({31'h0, err}, 32'h1);
    apb(1'b1, OCO_REG_CTRL1, 32'h1 << OCO_C1_ON);
    apb(1'b0, OCO_REG_CTRL1, 32'h0); chk(rd, 32'h1);
    r0 = rd_beats;
    w0 = wr_beats;
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_0104, 32'h0); chk(rd, ~32'h0000_0104);
    chk(beat_seq, seq_of(2'h1));
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_0108, 32'h0); chk(rd, ~32'h0000_0108);
    chk_cnt(rd_beats, r0 + 4);
    cpu(1'b1, 1'b0, 1'b1, 32'h0000_0108, 32'hcafe_0108);
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_0108, 32'h0); chk(rd, 32'hcafe_0108);
    cpu(1'b0, 1'b1, 1'b1, 32'h0000_0100, 32'h0); chk_cnt(wr_beats, w0);
    chk_cnt(rd_beats, r0 + 4);
    slow <= 2'h2;
    // Fill the other three ways of the set; the dirty line then becomes the victim
    for (int k = 1; k < 4; k++) cpu(1'b0, 1'b0, 1'b1, 32'h100 + 32'(k) * 32'h800, 32'h0);
    chk_cnt(rd_beats, r0 + 16);
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_210c, 32'h0); chk(rd, ~32'h0000_210c);
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_2100, 32'h0); chk(rd, ~32'h0000_2100);
    for (int i = 0; i < 200 && wr_beats < w0 + 4; i++) @(posedge sys_clk);
    chk_cnt(wr_beats, w0 + 4);
    chk(beat_seq, seq_of(2'h3));
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_0108, 32'h0); chk(rd, 32'hcafe_0108);
    r0 = rd_beats;
    cpu(1'b1, 1'b0, 1'b1, 32'h0000_4004, 32'h1234_4004); chk_cnt(rd_beats, r0 + 4);
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_4004, 32'h0); chk(rd, 32'h1234_4004);
    cpu(1'b0, 1'b1, 1'b1, 32'h0000_5000, 32'h0); chk(rd, 32'h1234_4004);
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_5000, 32'h0); chk_cnt(rd_beats, r0 + 8);
    cpu(1'b0, 1'b0, 1'b1, 32'h2000_0104, 32'h0);
    cpu(1'b0, 1'b0, 1'b1, 32'h2000_0104, 32'h0); chk_cnt(rd_beats, r0 + 16);
    apb(1'b1, OCO_REG_CTRL1, 32'h3);
    r0 = rd_beats;
    w0 = wr_beats;
    cpu(1'b1, 1'b0, 1'b1, 32'h0000_6000, 32'h0bad_6000); chk_cnt(wr_beats, w0 + 1);
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_6000, 32'h0); chk(rd, 32'h0bad_6000);
    chk_cnt(rd_beats, r0 + 4);
    cpu(1'b1, 1'b0, 1'b1, 32'h0000_6000, 32'h0bad_6001); chk_cnt(wr_beats, w0 + 2);
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_6000, 32'h0); chk(rd, 32'h0bad_6001);
    cpu(1'b0, 1'b0, 1'b0, 32'h0000_7000, 32'h0); chk_cnt(rd_beats, r0 + 5);
    apb(1'b1, OCO_REG_CTRL1, 32'h0);
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_6000, 32'h0); chk_cnt(rd_beats, r0 + 6);
    // Lock ways 2 and 3 and aim prefetches at way 3; only one fill target is ever set
    apb(1'b1, OCO_REG_CTRL1, 32'h1 << OCO_C1_ON);
    apb(1'b1, OCO_REG_CTRL2, 32'h0001_0301);
    apb(1'b0, OCO_REG_CTRL2, 32'h0); chk(rd, 32'h0001_0301);
    r0 = rd_beats;
    cpu(1'b0, 1'b1, 1'b1, 32'h0000_0200, 32'h0);
    // Four ordinary misses in the set would evict the prefetched line without the lock
    for (int k = 1; k < 5; k++) cpu(1'b0, 1'b0, 1'b1, 32'h200 + 32'(k) * 32'h800, 32'h0);
    cpu(1'b0, 1'b0, 1'b1, 32'h0000_0200, 32'h0); chk(rd, ~32'h0000_0200);
    chk_cnt(rd_beats, r0 + 20);
    give_verdict();
  end
endmodule
`default_nettype wire
